// file: motion_register_pkg.sv
package motion_register_pkg;
    // register numbering and width
    localparam int REG_COUNT = 9;
    localparam int REG_WIDTH = 32;
    localparam int REG_SEL_WIDTH = 4;
    localparam logic [3:0] REG_FIRST = 4'h1;
    localparam logic [3:0] REG_LAST = 4'h9;
    localparam logic [3:0] REG_EVENT_ONE = 4'h1;
    localparam logic [3:0] REG_EVENT_TWO = 4'h2;
    localparam logic [31:0] REG_RESET_VALUE = 32'h0000_0000;
    // operation codes from the low digit of the F field
    localparam logic [3:0] OP_LOAD = 4'h0;
    localparam logic [3:0] OP_SCALE = 4'h1;
    localparam logic [3:0] OP_MOVE = 4'h2;
    localparam logic [3:0] OP_ADD_SUB = 4'h3;
    localparam logic [3:0] OP_COMPARE = 4'h4;
    localparam logic [3:0] OP_FROM_ABS = 4'h5;
    localparam logic [3:0] OP_TO_ABS = 4'h6;
    localparam logic [3:0] OP_FROM_ENC = 4'h7;
    localparam logic [3:0] OP_FEEDRATE = 4'h8;
    localparam logic [3:0] OP_PARAM = 4'h9;
    localparam logic [3:0] OP_LAST = 4'h9;
    // configuration digit values that keep registers over cycle start
    localparam logic [3:0] KEEP_DIGIT_A = 4'h3;
    localparam logic [3:0] KEEP_DIGIT_B = 4'h4;
    localparam logic [3:0] KEEP_DIGIT_C = 4'h5;
    // bus map (word addresses, byte address = 4 * index)
    localparam int ADDR_WIDTH = 6;
    localparam logic [5:0] ADDR_REG_BASE = 6'h00;
    localparam logic [5:0] ADDR_COMMAND = 6'h0a;
    localparam logic [5:0] ADDR_SOURCE_VALUE = 6'h0b;
    localparam logic [5:0] ADDR_CONTROL = 6'h0c;
    localparam logic [5:0] ADDR_STATUS = 6'h0d;
    localparam logic [5:0] ADDR_X_ABS = 6'h0e;
    localparam logic [5:0] ADDR_Y_ABS = 6'h0f;
    localparam logic [5:0] ADDR_FEEDRATE = 6'h10;
    localparam logic [5:0] ADDR_PARAM_CODE = 6'h11;
    localparam logic [5:0] ADDR_PARAM_VALUE = 6'h12;
    localparam logic [5:0] ADDR_SCALE_X = 6'h13;
    localparam logic [5:0] ADDR_SCALE_Y = 6'h14;
    localparam logic [5:0] ADDR_BCD = 6'h15;
    // command word fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST_LSB = 4;
    localparam int CMD_SRC_LSB = 8;
    localparam int CMD_SRC_NEG_BIT = 12;
    localparam int CMD_AXIS_Y_BIT = 13;
    localparam int CMD_VALUE_GIVEN_BIT = 14;
    localparam int CMD_PARAM_LSB = 16;
    // control word fields
    localparam int CTL_CYCLE_START_BIT = 0;
    localparam int CTL_ACTIVE_Y_BIT = 1;
    localparam int CTL_KEEP_DIGIT_LSB = 4;
    localparam logic [31:0] CONTROL_RESET_VALUE = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h0000_0000;
    // status word bits
    localparam int ST_COMPARE_EQ_BIT = 0;
    localparam int ST_COMPARE_LT_BIT = 1;
    localparam int ST_TERMINATED_BIT = 2;
    localparam int ST_ABS_LOADED_BIT = 3;
    typedef enum logic [1:0] {IDLE, EXECUTE, ANSWER} bus_state_t;
endpackage : motion_register_pkg

// file: motion_register_file.sv
`timescale 1ns/1ps
module motion_register_file #(
    parameter int DEPTH = 9,
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // write port
    input wire logic clear_all_in,
    input wire logic write_en_in,
    input wire logic [3:0] write_sel_in,
    input wire logic [WIDTH-1:0] write_data_in,
    // event counters
    input wire logic [1:0] count_en_in,
    // read ports
    input wire logic [3:0] read_a_sel_in,
    input wire logic [3:0] read_b_sel_in,
    output logic [WIDTH-1:0] read_a_out,
    output logic [WIDTH-1:0] read_b_out
);
    import motion_register_pkg::*;
    logic [WIDTH-1:0] mem [DEPTH];
    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_reg
            always_ff @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    mem[i] <= WIDTH'(REG_RESET_VALUE);
                end else if (clear_all_in) begin
                    mem[i] <= WIDTH'(REG_RESET_VALUE);
                end else if (write_en_in && write_sel_in == 4'(i + 1)) begin
                    mem[i] <= write_data_in;
                end else if (i < 2 && count_en_in[i]) begin
                    // counters only step when no command writes them
                    mem[i] <= mem[i] + WIDTH'(1);
                end
            end
        end
    endgenerate
    // registered read data; index 0 and out of range read zero
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            read_a_out <= '0;
            read_b_out <= '0;
        end else begin
            read_a_out <= (read_a_sel_in >= REG_FIRST
                && read_a_sel_in <= REG_LAST) ? mem[read_a_sel_in - 4'h1] : '0;
            read_b_out <= (read_b_sel_in >= REG_FIRST
                && read_b_sel_in <= REG_LAST) ? mem[read_b_sel_in - 4'h1] : '0;
        end
    end
endmodule : motion_register_file

// file: motion_register_ops.sv
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// What this block does
// - rising edges on testable inputs 1 and 2 count up registers 1 and 2.
// - low F digit selects operation; other digit or source names register 1-9.
// - op 0 loads destination with the given source value, else with external BCD data.
// - op 1 multiplies destination by the active axis scale factor.
// - op 2 copies source register into destination register.
// - op 3 adds source when sign plus, subtracts when sign minus.
// - op 4 compares destination with selected axis absolute position, kept.
// - op 5 loads destination with selected axis absolute position.
// - op 6 overwrites selected axis absolute position with destination.
// - op 7 loads destination with X encoder position.
// - op 8 sets active feedrate from destination register.
// - op 9 writes destination value into the commanded parameter code.
// - out-of-range F field data terminates program execution.
// - cycle start clears all nine registers; resume keeps them.
// - configuration digit 3, 4 or 5 suppresses the cycle start clear.
module motion_register_ops #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // avalon-mm slave
    input wire logic [motion_register_pkg::ADDR_WIDTH-1:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    // testable inputs from pins
    input wire logic [1:0] testable_input_in,
    // position sources
    input wire logic [WIDTH-1:0] x_encoder_position_in,
    // axis and program outputs
    output logic [WIDTH-1:0] x_absolute_position_out,
    output logic [WIDTH-1:0] y_absolute_position_out,
    output logic [WIDTH-1:0] feedrate_out,
    output logic [7:0] param_code_out,
    output logic [WIDTH-1:0] param_value_out,
    output logic param_write_out,
    output logic program_terminate_out
);
    import motion_register_pkg::*;

    bus_state_t state;
    logic [31:0] command;
    logic [31:0] source_value;
    logic [31:0] control;
    logic [WIDTH-1:0] scale_x;
    logic [WIDTH-1:0] scale_y;
    logic [WIDTH-1:0] bcd_data;
    logic compare_eq;
    logic compare_lt;
    logic terminated;
    logic abs_loaded;
    logic [1:0] in_meta;
    logic [1:0] in_sync;
    logic [1:0] in_last;
    logic [1:0] count_en;
    logic [5:0] hold_addr;
    logic hold_write;
    logic [31:0] hold_data;
    logic cmd_start;
    logic cycle_start;
    logic clear_all;
    logic rf_write;
    logic [3:0] rf_sel;
    logic [WIDTH-1:0] rf_data;
    logic [WIDTH-1:0] dest_val;
    logic [WIDTH-1:0] src_val;
    logic [3:0] op;
    logic [3:0] dest_sel;
    logic [3:0] src_sel;
    logic src_neg;
    logic axis_y;
    logic value_given;
    logic op_valid;
    logic [WIDTH-1:0] axis_abs;
    logic [WIDTH-1:0] active_scale;
    logic signed [2*WIDTH-1:0] product;
    logic [3:0] keep_digit;
    logic keep_regs;
    logic [31:0] next_readdata;

    assign op = command[CMD_OP_LSB +: 4];
    assign dest_sel = command[CMD_DEST_LSB +: 4];
    assign src_sel = command[CMD_SRC_LSB +: 4];
    assign src_neg = command[CMD_SRC_NEG_BIT];
    assign axis_y = command[CMD_AXIS_Y_BIT];
    assign value_given = command[CMD_VALUE_GIVEN_BIT];
    assign keep_digit = control[CTL_KEEP_DIGIT_LSB +: 4];
    assign axis_abs = axis_y ? y_absolute_position_out
        : x_absolute_position_out;
    assign active_scale = control[CTL_ACTIVE_Y_BIT] ? scale_y : scale_x;

    // two-stage synchroniser, edge taken from the second stage only
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            in_meta <= 2'h0;
            in_sync <= 2'h0;
            in_last <= 2'h0;
        end else begin
            in_meta <= testable_input_in;
            in_sync <= in_meta;
            in_last <= in_sync;
        end
    end
    assign count_en = in_sync & ~in_last;

    // avalon handshake: two wait cycles (IDLE and EXECUTE) let register-file reads settle
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= IDLE;
            hold_addr <= 6'h00;
            hold_write <= 1'b0;
            hold_data <= 32'h0000_0000;
        end else begin
            case (state)
                IDLE: begin
                    if (read_in || write_in) begin
                        state <= EXECUTE;
                        hold_addr <= address_in;
                        hold_write <= write_in;
                        hold_data <= writedata_in;
                    end
                end
                EXECUTE: state <= ANSWER;
                ANSWER: state <= IDLE;
                default: state <= IDLE;
            endcase
        end
    end
    assign waitrequest_out = (state != ANSWER);

    logic wr_take;
    assign wr_take = (state == EXECUTE) && hold_write;
    assign cmd_start = (state == ANSWER) && hold_write
        && hold_addr == ADDR_COMMAND;
    assign cycle_start = wr_take && hold_addr == ADDR_CONTROL
        && hold_data[CTL_CYCLE_START_BIT];
    assign keep_regs = keep_digit == KEEP_DIGIT_A
        || keep_digit == KEEP_DIGIT_B || keep_digit == KEEP_DIGIT_C;
    assign clear_all = cycle_start && !keep_regs;

    // software-written configuration; byte enables respected for command, source value and control only
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) res[8*b +: 8] = data[8*b +: 8];
        end
        return res;
    endfunction : merge

    logic [3:0] hold_be;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            hold_be <= 4'h0;
        end else if (state == IDLE) begin
            hold_be <= byteenable_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            command <= 32'h0000_0000;
            source_value <= 32'h0000_0000;
            control <= CONTROL_RESET_VALUE;
            scale_x <= WIDTH'(1);
            scale_y <= WIDTH'(1);
            bcd_data <= '0;
        end else if (wr_take) begin
            case (hold_addr)
                ADDR_COMMAND: command <= merge(command, hold_data, hold_be);
                ADDR_SOURCE_VALUE: begin
                    source_value <= merge(source_value, hold_data, hold_be);
                end
                ADDR_CONTROL: begin
                    // cycle start bit is a strobe, never stored
                    control <= merge(control, hold_data, hold_be)
                        & ~(32'h1 << CTL_CYCLE_START_BIT);
                end
                ADDR_SCALE_X: scale_x <= WIDTH'(hold_data);
                ADDR_SCALE_Y: scale_y <= WIDTH'(hold_data);
                ADDR_BCD: bcd_data <= WIDTH'(hold_data);
                default: begin
                end
            endcase
        end
    end

    // operation decode and range check
    assign op_valid = op <= OP_LAST && dest_sel >= REG_FIRST
        && dest_sel <= REG_LAST && (op != OP_MOVE && op != OP_ADD_SUB
        || (src_sel >= REG_FIRST && src_sel <= REG_LAST));

    // product keeps the low word; overflow wraps
    assign product = $signed(dest_val) * $signed(active_scale);

    always_comb begin
        rf_write = 1'b0;
        rf_sel = dest_sel;
        rf_data = dest_val;
        if (cmd_start && op_valid) begin
            case (op)
                OP_LOAD: begin
                    rf_write = 1'b1;
                    rf_data = value_given ? WIDTH'(source_value)
                        : bcd_data;
                end
                OP_SCALE: begin
                    rf_write = 1'b1;
                    rf_data = product[WIDTH-1:0];
                end
                OP_MOVE: begin
                    rf_write = 1'b1;
                    rf_data = src_val;
                end
                OP_ADD_SUB: begin
                    rf_write = 1'b1;
                    rf_data = src_neg ? WIDTH'($signed(dest_val)
                        - $signed(src_val))
                        : WIDTH'($signed(dest_val) + $signed(src_val));
                end
                OP_FROM_ABS: begin
                    rf_write = 1'b1;
                    rf_data = axis_abs;
                end
                OP_FROM_ENC: begin
                    rf_write = 1'b1;
                    rf_data = x_encoder_position_in;
                end
                default: rf_write = 1'b0;
            endcase
        end
    end

    motion_register_file #(
        .DEPTH(REG_COUNT),
        .WIDTH(WIDTH)
    ) u_regs (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .clear_all_in(clear_all),
        .write_en_in(rf_write),
        .write_sel_in(rf_sel),
        .write_data_in(rf_data),
        .count_en_in(count_en),
        .read_a_sel_in(state == IDLE ? address_in[3:0]
            : wr_take && hold_addr == ADDR_COMMAND
            ? hold_data[CMD_DEST_LSB +: 4] : hold_addr[3:0]),
        .read_b_sel_in(hold_data[CMD_SRC_LSB +: 4]),
        .read_a_out(dest_val),
        .read_b_out(src_val)
    );

    // compare, terminate and axis side effects
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            compare_eq <= 1'b0;
            compare_lt <= 1'b0;
            terminated <= 1'b0;
            abs_loaded <= 1'b0;
            x_absolute_position_out <= '0;
            y_absolute_position_out <= '0;
            feedrate_out <= '0;
            param_code_out <= 8'h00;
            param_value_out <= '0;
            param_write_out <= 1'b0;
        end else begin
            param_write_out <= 1'b0;
            if (cycle_start) begin
                terminated <= 1'b0;
            end
            if (wr_take && hold_addr == ADDR_X_ABS) begin
                x_absolute_position_out <= WIDTH'(hold_data);
            end
            if (wr_take && hold_addr == ADDR_Y_ABS) begin
                y_absolute_position_out <= WIDTH'(hold_data);
            end
            if (cmd_start && !op_valid) begin
                terminated <= 1'b1;
            end
            if (cmd_start && op_valid) begin
                case (op)
                    OP_COMPARE: begin
                        compare_eq <= dest_val == axis_abs;
                        compare_lt <= $signed(dest_val) < $signed(axis_abs);
                    end
                    OP_TO_ABS: begin
                        abs_loaded <= 1'b1;
                        if (axis_y) begin
                            y_absolute_position_out <= dest_val;
                        end else begin
                            x_absolute_position_out <= dest_val;
                        end
                    end
                    OP_FEEDRATE: feedrate_out <= dest_val;
                    OP_PARAM: begin
                        param_code_out <= command[CMD_PARAM_LSB +: 8];
                        param_value_out <= dest_val;
                        param_write_out <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
    assign program_terminate_out = terminated;

    always_comb begin
        next_readdata = UNMAPPED_READ_VALUE;
        if (hold_addr >= ADDR_REG_BASE + 6'(REG_FIRST)
            && hold_addr <= ADDR_REG_BASE + 6'(REG_LAST)) begin
            next_readdata = 32'(dest_val);
        end else begin
            case (hold_addr)
                ADDR_COMMAND: next_readdata = command;
                ADDR_SOURCE_VALUE: next_readdata = source_value;
                ADDR_CONTROL: next_readdata = control;
                ADDR_STATUS: begin
                    next_readdata[ST_COMPARE_EQ_BIT] = compare_eq;
                    next_readdata[ST_COMPARE_LT_BIT] = compare_lt;
                    next_readdata[ST_TERMINATED_BIT] = terminated;
                    next_readdata[ST_ABS_LOADED_BIT] = abs_loaded;
                end
                ADDR_X_ABS: next_readdata = 32'(x_absolute_position_out);
                ADDR_Y_ABS: next_readdata = 32'(y_absolute_position_out);
                ADDR_FEEDRATE: next_readdata = 32'(feedrate_out);
                ADDR_PARAM_CODE: next_readdata = 32'(param_code_out);
                ADDR_PARAM_VALUE: next_readdata = 32'(param_value_out);
                ADDR_SCALE_X: next_readdata = 32'(scale_x);
                ADDR_SCALE_Y: next_readdata = 32'(scale_y);
                ADDR_BCD: next_readdata = 32'(bcd_data);
                default: next_readdata = UNMAPPED_READ_VALUE;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            readdata_out <= 32'h0000_0000;
        end else if (state == EXECUTE) begin
            readdata_out <= next_readdata;
        end
    end
endmodule : motion_register_ops

// file: motion_register_ops_chk.sv
`timescale 1ns/1ps
module motion_register_ops_chk #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // bus
    input wire logic [motion_register_pkg::ADDR_WIDTH-1:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    input wire logic waitrequest_out,
    // outputs
    input wire logic [WIDTH-1:0] x_absolute_position_out,
    input wire logic [WIDTH-1:0] feedrate_out,
    input wire logic [7:0] param_code_out,
    input wire logic param_write_out,
    input wire logic program_terminate_out
);
    import motion_register_pkg::*;
    logic ans, cmd, bad, op8, op9, cyc;
    logic [3:0] dst;
    // only full-word writes are judged
    assign ans = write_in && !waitrequest_out && byteenable_in == 4'hf;
    assign cmd = ans && address_in == ADDR_COMMAND;
    assign dst = writedata_in[7:4];
    assign bad = cmd && (writedata_in[3:0] > OP_LAST || dst < REG_FIRST
        || dst > REG_LAST);
    assign op8 = (cmd && !bad && writedata_in[3:0] == OP_FEEDRATE)
        || (ans && address_in == ADDR_FEEDRATE);
    assign op9 = cmd && !bad && writedata_in[3:0] == OP_PARAM;
    assign cyc = ans && address_in == ADDR_CONTROL && writedata_in[0];
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    chk_wait_bound: assert property ((read_in || write_in)
        |-> ##[0:2] !waitrequest_out)
        else $error("bus answer late");
    chk_wait_idle: assert property (!(read_in || write_in)
        |-> waitrequest_out)
        else $error("waitrequest low while idle");
    chk_bad_term: assert property (bad |=> program_terminate_out)
        else $error("bad command did not terminate");
    // the clear lands at the end of the wait cycle, seen during the answer
    chk_term_hold: assert property ($fell(program_terminate_out)
        |-> cyc)
        else $error("terminate dropped without cycle start");
    chk_cycle_clear: assert property (cyc |=> !program_terminate_out)
        else $error("cycle start kept terminate");
    chk_param_pulse: assert property (op9 |=> param_write_out
        ##1 !param_write_out)
        else $error("parameter strobe not one cycle");
    chk_param_code: assert property (op9
        |=> param_code_out == $past(writedata_in[23:16]))
        else $error("parameter code wrong");
    chk_param_cause: assert property (param_write_out |-> $past(op9))
        else $error("parameter strobe without command");
    chk_feed_cause: assert property ($changed(feedrate_out)
        |-> $past(op8))
        else $error("feedrate changed without command");
    chk_xabs_cause: assert property ($changed(x_absolute_position_out)
        |-> ans || $past(ans))
        else $error("x position changed without write");
endmodule : motion_register_ops_chk

bind motion_register_ops motion_register_ops_chk #(.WIDTH(WIDTH)) chk_i (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .byteenable_in(byteenable_in), .waitrequest_out(waitrequest_out),
    .x_absolute_position_out(x_absolute_position_out),
    .feedrate_out(feedrate_out), .param_code_out(param_code_out),
    .param_write_out(param_write_out),
    .program_terminate_out(program_terminate_out));

// file: program_sequencer_model.sv
`timescale 1ns/1ps
module program_sequencer_model (
    // clock
    input wire logic mclk_in,
    // bus master
    output logic [motion_register_pkg::ADDR_WIDTH-1:0] address_out,
    output logic read_out,
    output logic write_out,
    output logic [31:0] writedata_out,
    input wire logic [31:0] readdata_in,
    input wire logic waitrequest_in
);
    import motion_register_pkg::*;
    initial begin
        address_out = '0;
        read_out = 1'b0;
        write_out = 1'b0;
        writedata_out = '0;
    end

    // idle data lines are scrambled so stale values cannot pass
    task automatic xfer(input logic w, input logic [5:0] a,
            input logic [31:0] d, input int gap,
            output logic [31:0] q, output bit ok);
        int k;
        repeat (gap + 1) @(posedge mclk_in);
        address_out <= a;
        read_out <= ~w;
        write_out <= w;
        writedata_out <= w ? d : ~d;
        k = 0;
        do begin
            @(posedge mclk_in);
            k++;
        end while (waitrequest_in !== 1'b0 && k < 16);
        ok = (waitrequest_in === 1'b0);
        q = readdata_in;
        read_out <= 1'b0;
        write_out <= 1'b0;
        writedata_out <= ~d;
    endtask : xfer
endmodule : program_sequencer_model

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
    import motion_register_pkg::*;
    logic mclk_in, rstn_in, rd_s, wr_s, wt, pwr, term;
    logic [5:0] adr;
    logic [1:0] tin;
    logic [7:0] pcode;
    logic [31:0] wd, rdat, xenc, xabs, yabs, feed, pval, q, v;
    logic [31:0] r [1:9];
    int n_errors, n_checks, seed;

    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end

    motion_register_ops motion_register_ops_i (
        .mclk_in(mclk_in), .rstn_in(rstn_in), .address_in(adr),
        .read_in(rd_s), .write_in(wr_s), .writedata_in(wd),
        .byteenable_in(4'hf), .readdata_out(rdat), .waitrequest_out(wt),
        .testable_input_in(tin), .x_encoder_position_in(xenc),
        .x_absolute_position_out(xabs), .y_absolute_position_out(yabs),
        .feedrate_out(feed), .param_code_out(pcode),
        .param_value_out(pval), .param_write_out(pwr),
        .program_terminate_out(term));

    program_sequencer_model program_sequencer_model_i (
        .mclk_in(mclk_in), .address_out(adr), .read_out(rd_s),
        .write_out(wr_s), .writedata_out(wd), .readdata_in(rdat),
        .waitrequest_in(wt));

    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic bus(input logic w, input logic [5:0] a,
            input logic [31:0] d);
        bit ok;
        program_sequencer_model_i.xfer(w, a, d, $random(seed) & 3, q, ok);
        if (!ok) begin
            n_errors++;
            give_verdict();
        end
    endtask : bus

    // extra edge lets the command's results land before they are looked at
    task automatic op(input logic [3:0] o, input logic [3:0] d,
            input logic [3:0] s, input logic [2:0] f,
            input logic [7:0] p = 8'h00);
        bus(1'b1, ADDR_COMMAND, {8'h00, p, 1'b0, f, s, d, o});
        @(posedge mclk_in);
    endtask : op

    function automatic logic [31:0] add_sub(input logic [31:0] a,
            input logic [31:0] b, input logic neg);
        return neg ? a - b : a + b;
    endfunction : add_sub

    task automatic chk_regs;
        for (int i = 1; i <= 9; i++) begin
            bus(1'b0, 6'(i), 32'h0);
            check(q, r[i]);
        end
    endtask : chk_regs

    initial begin
        repeat (100000) @(posedge mclk_in);
        n_errors++;
        give_verdict();
    end

    initial begin
        seed = 32'h52bb;
        rstn_in = 1'b0;
        tin = 2'b00;
        xenc = 32'h0;
        repeat (4) @(posedge mclk_in);
        rstn_in <= 1'b1;
        @(posedge mclk_in);
        check(32'(wt), 32'h1);
        for (int i = 1; i <= 9; i++) begin
            r[i] = $random(seed);
            bus(1'b1, ADDR_SOURCE_VALUE, r[i]);
            op(OP_LOAD, 4'(i), 4'h0, 3'b100);
        end
        bus(1'b1, ADDR_BCD, r[1] ^ r[2]);
        op(OP_LOAD, 4'h7, 4'h0, 3'b000);
        r[7] = r[1] ^ r[2];
        chk_regs();
        op(OP_MOVE, 4'h4, 4'h9, 3'b000);
        r[4] = r[9];
        op(OP_ADD_SUB, 4'h5, 4'h3, 3'b000);
        r[5] = add_sub(r[5], r[3], 1'b0);
        op(OP_ADD_SUB, 4'h6, 4'h7, 3'b001);
        r[6] = add_sub(r[6], r[7], 1'b1);
        v = $random(seed) & 32'hff;
        bus(1'b1, ADDR_SCALE_Y, v);
        bus(1'b1, ADDR_CONTROL, 32'h2);
        op(OP_SCALE, 4'h8, 4'h0, 3'b000);
        r[8] = r[8] * v;
        // registers are read-only from the bus
        bus(1'b1, 6'h07, 32'h1234);
        chk_regs();
        op(OP_TO_ABS, 4'h3, 4'h0, 3'b000);
        op(OP_TO_ABS, 4'h4, 4'h0, 3'b010);
        check(xabs, r[3]);
        check(yabs, r[4]);
        op(OP_FROM_ABS, 4'h5, 4'h0, 3'b010);
        r[5] = r[4];
        xenc <= $random(seed);
        op(OP_FROM_ENC, 4'h6, 4'h0, 3'b000);
        r[6] = xenc;
        op(OP_COMPARE, 4'h3, 4'h0, 3'b000);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check(32'(q[1:0]), 32'h1);
        check(32'(q[3]), 32'h1);
        r[9] = r[3] - 32'h1;
        bus(1'b1, ADDR_SOURCE_VALUE, r[9]);
        op(OP_LOAD, 4'h9, 4'h0, 3'b100);
        op(OP_COMPARE, 4'h9, 4'h0, 3'b000);
        op(OP_FEEDRATE, 4'h2, 4'h0, 3'b000);
        check(feed, r[2]);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check(32'(q[1:0]), 32'h2);
        v = $random(seed) & 32'hff;
        op(OP_PARAM, 4'h8, 4'h0, 3'b000, v[7:0]);
        check(32'(pcode), v);
        check(pval, r[8]);
        bus(1'b0, 6'h3f, 32'h0);
        check(q, 32'h0);
        chk_regs();
        op(4'hc, 4'h1, 4'h0, 3'b000);
        check(32'(term), 32'h1);
        op(OP_LOAD, 4'h0, 4'h0, 3'b100);
        bus(1'b0, ADDR_STATUS, 32'h0);
        check(32'(q[2]), 32'h1);
        for (int k = 3; k <= 5; k++) begin
            // keep digit must already stand when the strobe arrives
            bus(1'b1, ADDR_CONTROL, 32'(k << 4));
            bus(1'b1, ADDR_CONTROL, 32'(k << 4) | 32'h1);
            chk_regs();
        end
        bus(1'b1, ADDR_CONTROL, 32'h20);
        bus(1'b1, ADDR_CONTROL, 32'h21);
        for (int i = 1; i <= 9; i++) r[i] = 32'h0;
        chk_regs();
        check(32'(term), 32'h0);
        for (int k = 0; k < 3; k++) begin
            tin <= (k < 2) ? 2'b11 : 2'b01;
            repeat (4) @(posedge mclk_in);
            tin <= 2'b00;
            repeat (4) @(posedge mclk_in);
        end
        r[1] = 32'h3;
        r[2] = 32'h2;
        chk_regs();
        give_verdict();
    end
endmodule : testbench
